// >>> include/tclr_pkg.sv
// Package for the touch calibration, LED duty and channel readback register group.
// Assumes an 8-bit register address space reached by the serial-link register engine.
package tclr_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_BS_CAL_SPEED = 8'h42;
  localparam logic [7:0] ADDR_LED_DUTY_12 = 8'h43;
  localparam logic [7:0] ADDR_LED_DUTY_34 = 8'h44;
  localparam logic [7:0] ADDR_LED_DUTY_56 = 8'h45;
  localparam logic [7:0] ADDR_LED_DUTY_78 = 8'h46;
  localparam logic [7:0] ADDR_OUT_FUNC_SEL = 8'h4f;
  localparam logic [7:0] ADDR_RD_CH_HIGH_A = 8'h50;
  localparam logic [7:0] ADDR_RD_CH_LOW_A = 8'h51;
  localparam logic [7:0] ADDR_LEVEL_UPPER = 8'h52;
  localparam logic [7:0] ADDR_LEVEL_MIDDLE = 8'h53;
  localparam logic [7:0] ADDR_LEVEL_LOWER = 8'h54;
  localparam logic [7:0] ADDR_RD_CH_HIGH_B = 8'h56;
  localparam logic [7:0] ADDR_RD_CH_LOW_B = 8'h57;

  // Field positions inside the calibration speed register
  localparam int SENSE_FALL_LSB = 0;
  localparam int SENSE_RISE_LSB = 2;
  localparam int REF_FALL_LSB = 4;
  localparam int REF_RISE_LSB = 6;

  // Values after reset
  localparam logic [1:0] CAL_FALL_RST = 2'h2;
  localparam logic [1:0] CAL_RISE_RST = 2'h1;
  localparam logic [3:0] LED_DUTY_RST = 4'h0;
  localparam logic [7:0] OUT_FUNC_RST = 8'h00;

  // Calibration rate encodings
  typedef enum logic [1:0] {
    TCLR_RATE_FASTEST = 2'b00,
    TCLR_RATE_FAST = 2'b01,
    TCLR_RATE_NORMAL = 2'b10,
    TCLR_RATE_SLOW = 2'b11
  } tclr_rate_e;

  // Channel codes from the sensing engine: 0 is the noise reference, 1..8 the touch inputs
  localparam logic [3:0] CH_NOISE_REF = 4'h0;
  localparam logic [3:0] CH_LAST = 4'h8;

  // LED PWM timing: core cycles per slot, and slots per period
  localparam logic [7:0] PWM_SLOT_CYCLES = 8'h80;
  localparam logic [4:0] PWM_SLOTS = 5'h11;

  localparam int NUM_PORTS = 8;
  localparam int LEVEL_W = 26;
endpackage : tclr_pkg

// >>> core/tclr_regs.sv
// Touch calibration speed, LED duty, output function and channel readback registers.
// Assumes a register engine behind the serial link gives byte address, write and read strobes,
// and the sensing engine gives the channel under readout with its touch level.
// Reset is asynchronous and active high; all outputs come from registers.
// The drive pins are open drain: the enable pulls low, the value is never high.
`timescale 1ns/10ps
module tclr_regs (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic secondary_calibration_mode_i,
  input wire logic [tclr_pkg::NUM_PORTS-1:0] touch_result_i,
  input wire logic sample_valid_i,
  input wire logic [3:0] sample_channel_i,
  input wire logic [tclr_pkg::LEVEL_W-1:0] sample_level_i,
  output logic cal_rates_active_o,
  output logic [1:0] sense_cal_rate_falling_o,
  output logic [1:0] sense_cal_rate_rising_o,
  output logic [1:0] noise_ref_cal_rate_falling_o,
  output logic [1:0] noise_ref_cal_rate_rising_o,
  output logic [tclr_pkg::NUM_PORTS-1:0] drive_output_port_o,
  output logic [tclr_pkg::NUM_PORTS-1:0] drive_output_port_oe_o
);
  import tclr_pkg::*;

  // Host-writable state
  logic [7:0] cal_speed_reg;
  logic [7:0] cal_speed_next;
  logic [31:0] led_duty_reg;
  logic [31:0] led_duty_next;
  logic [7:0] out_func_reg;
  logic [7:0] out_func_next;
  // Captured readback snapshot, indication and level loaded by one strobe
  logic [7:0] ind_high_reg;
  logic [7:0] ind_high_next;
  logic [1:0] ind_low_reg;
  logic [1:0] ind_low_next;
  logic [23:0] level_reg;
  logic [23:0] level_next;
  logic sample_take;
  // Read port
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  // Calibration outputs
  logic [7:0] cal_out_reg;
  logic [7:0] cal_out_next;
  logic cal_act_reg;
  logic cal_act_next;
  // PWM timing
  logic [7:0] slot_cnt_reg;
  logic [7:0] slot_cnt_next;
  logic [4:0] phase_reg;
  logic [4:0] phase_next;
  logic slot_tick;
  logic [NUM_PORTS-1:0] pwm_low;
  logic [NUM_PORTS-1:0] oe_reg;
  logic [NUM_PORTS-1:0] oe_next;
  // Pin value register; open drain, so it only ever holds low
  logic [NUM_PORTS-1:0] pin_val_reg;
  logic [NUM_PORTS-1:0] pin_val_next;

  // Host writes; read-only addresses fall through unchanged
  // A write to a read-only or unmapped address leaves every register as it was
  always_comb begin
    cal_speed_next = cal_speed_reg;
    led_duty_next = led_duty_reg;
    out_func_next = out_func_reg;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        ADDR_BS_CAL_SPEED: cal_speed_next = reg_wdata_i;
        ADDR_LED_DUTY_12: led_duty_next[7:0] = reg_wdata_i;
        ADDR_LED_DUTY_34: led_duty_next[15:8] = reg_wdata_i;
        ADDR_LED_DUTY_56: led_duty_next[23:16] = reg_wdata_i;
        ADDR_LED_DUTY_78: led_duty_next[31:24] = reg_wdata_i;
        ADDR_OUT_FUNC_SEL: out_func_next = reg_wdata_i;
        default: ;
      endcase
    end
  end

  // Host register storage with reset values
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cal_speed_reg <= {CAL_RISE_RST, CAL_FALL_RST, CAL_RISE_RST, CAL_FALL_RST};
      led_duty_reg <= {8{LED_DUTY_RST}};
      out_func_reg <= OUT_FUNC_RST;
    end else begin
      cal_speed_reg <= cal_speed_next;
      led_duty_reg <= led_duty_next;
      out_func_reg <= out_func_next;
    end
  end

  // Calibration rates handed to the engine, flagged active only in secondary mode
  // Rates always follow the register; the engine applies them only while the flag is high
  always_comb begin
    cal_out_next = cal_speed_reg;
    cal_act_next = secondary_calibration_mode_i;
  end

  // Rate copy and mode flag, one cycle behind their sources
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cal_out_reg <= {CAL_RISE_RST, CAL_FALL_RST, CAL_RISE_RST, CAL_FALL_RST};
      cal_act_reg <= 1'b0;
    end else begin
      cal_out_reg <= cal_out_next;
      cal_act_reg <= cal_act_next;
    end
  end

  // Rate fields sliced from the registered copy
  assign sense_cal_rate_falling_o = cal_out_reg[SENSE_FALL_LSB +: 2];
  assign sense_cal_rate_rising_o = cal_out_reg[SENSE_RISE_LSB +: 2];
  assign noise_ref_cal_rate_falling_o = cal_out_reg[REF_FALL_LSB +: 2];
  assign noise_ref_cal_rate_rising_o = cal_out_reg[REF_RISE_LSB +: 2];
  assign cal_rates_active_o = cal_act_reg;

  // One strobe loads channel and level together so the bytes always agree
  assign sample_take = sample_valid_i && (sample_channel_i <= CH_LAST);

  // Channel indication, one-hot over noise reference and touch inputs
  always_comb begin
    ind_high_next = ind_high_reg;
    ind_low_next = ind_low_reg;
    if (sample_take) begin
      ind_high_next = 8'h00;
      ind_low_next = 2'h0;
      if (sample_channel_i == CH_NOISE_REF) begin
        ind_high_next = 8'h02;
      end else if (sample_channel_i <= 4'h6) begin
        ind_high_next = 8'(8'h02 << sample_channel_i);
      end else begin
        ind_low_next = (sample_channel_i == 4'h7) ? 2'h1 : 2'h2;
      end
    end
  end

  // Indication registers, cleared by reset
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ind_high_reg <= 8'h00;
      ind_low_reg <= 2'h0;
    end else begin
      ind_high_reg <= ind_high_next;
      ind_low_reg <= ind_low_next;
    end
  end

  // Level snapshot; the two lowest bits of the level are dropped
  always_comb begin
    level_next = level_reg;
    if (sample_take) begin
      level_next = sample_level_i[LEVEL_W-1:2];
    end
  end

  // Level register, cleared by reset
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      level_reg <= 24'h000000;
    end else begin
      level_reg <= level_next;
    end
  end

  // Read mux, answered one cycle after the strobe; unmapped reads give zero
  always_comb begin
    rvalid_next = reg_rd_i;
    rdata_next = rdata_reg;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_BS_CAL_SPEED: rdata_next = cal_speed_reg;
        ADDR_LED_DUTY_12: rdata_next = led_duty_reg[7:0];
        ADDR_LED_DUTY_34: rdata_next = led_duty_reg[15:8];
        ADDR_LED_DUTY_56: rdata_next = led_duty_reg[23:16];
        ADDR_LED_DUTY_78: rdata_next = led_duty_reg[31:24];
        ADDR_OUT_FUNC_SEL: rdata_next = out_func_reg;
        ADDR_RD_CH_HIGH_A: rdata_next = ind_high_reg;
        ADDR_RD_CH_LOW_A: rdata_next = {6'h00, ind_low_reg};
        ADDR_LEVEL_UPPER: rdata_next = level_reg[23:16];
        ADDR_LEVEL_MIDDLE: rdata_next = level_reg[15:8];
        ADDR_LEVEL_LOWER: rdata_next = level_reg[7:0];
        ADDR_RD_CH_HIGH_B: rdata_next = ind_high_reg;
        ADDR_RD_CH_LOW_B: rdata_next = {6'h00, ind_low_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Read answer registers; data holds until the next read
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // Read port outputs
  assign reg_rdata_o = rdata_reg;
  assign reg_rvalid_o = rvalid_reg;

  // Slot divider: one-cycle tick every PWM_SLOT_CYCLES core cycles
  assign slot_tick = (slot_cnt_reg == PWM_SLOT_CYCLES - 8'h01);

  always_comb begin
    slot_cnt_next = slot_tick ? 8'h00 : slot_cnt_reg + 8'h01;
  end

  // Slot counter register
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      slot_cnt_reg <= 8'h00;
    end else begin
      slot_cnt_reg <= slot_cnt_next;
    end
  end

  // Period phase shared by all ports, so every port starts its period together
  always_comb begin
    phase_next = phase_reg;
    if (slot_tick) begin
      phase_next = (phase_reg == PWM_SLOTS - 5'h01) ? 5'h00 : phase_reg + 5'h01;
    end
  end

  // Phase register
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phase_reg <= 5'h00;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // Per port: low for duty+1 of 17 slots in LED mode, else follows touch result
  // Code zero still gives one low slot, so the dimmest setting is not fully dark
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      assign pwm_low[gp] = (phase_reg <= {1'b0, led_duty_reg[gp*4 +: 4]});
    end
  endgenerate

  // Pull-down enable: LED ports follow the low slots, touch ports the touch result
  always_comb begin
    oe_next = (out_func_reg & pwm_low) | (~out_func_reg & touch_result_i);
  end

  // Enable register, released by reset
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      oe_reg <= '0;
    end else begin
      oe_reg <= oe_next;
    end
  end

  // Pin value: open drain, never driven high
  always_comb begin
    pin_val_next = '0;
  end

  // Pin value register
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_val_reg <= '0;
    end else begin
      pin_val_reg <= pin_val_next;
    end
  end

  // Open-drain pins only ever pull low
  assign drive_output_port_oe_o = oe_reg;
  assign drive_output_port_o = pin_val_reg;
endmodule : tclr_regs

// >>> verification/tclr_regs_sva.sv
// Checker for the register group: answer strobe, rate fields, readback timing.
// Assumes it is bound to tclr_regs and sees only that module's ports.
`timescale 1ns/10ps
module tclr_regs_sva (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic secondary_calibration_mode_i,
  input wire logic sample_valid_i,
  input wire logic [3:0] sample_channel_i,
  input wire logic cal_rates_active_o,
  input wire logic [1:0] sense_cal_rate_falling_o,
  input wire logic [1:0] sense_cal_rate_rising_o,
  input wire logic [1:0] noise_ref_cal_rate_falling_o,
  input wire logic [1:0] noise_ref_cal_rate_rising_o,
  input wire logic [7:0] drive_output_port_oe_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Speed register write lands in one field
  property wr42_p(logic [1:0] f, logic [1:0] w);
    reg_wr_i && reg_addr_i == 8'h42 |=> ##1 f == $past(w, 2);
  endproperty
  a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read answer missing");
  a_sense_fall: assert property (wr42_p(sense_cal_rate_falling_o, reg_wdata_i[1:0])) else $error("sense fall");
  a_sense_rise: assert property (wr42_p(sense_cal_rate_rising_o, reg_wdata_i[3:2])) else $error("sense rise");
  a_ref_fall: assert property (wr42_p(noise_ref_cal_rate_falling_o, reg_wdata_i[5:4])) else $error("ref fall");
  a_ref_rise: assert property (wr42_p(noise_ref_cal_rate_rising_o, reg_wdata_i[7:6])) else $error("ref rise");
  a_mode_follow: assert property ($rose(secondary_calibration_mode_i) |=> cal_rates_active_o) else $error("mode");
  a_duty_readback: assert property (reg_wr_i && reg_addr_i == 8'h43 ##2 reg_rd_i && reg_addr_i == 8'h43
    |=> reg_rdata_o == $past(reg_wdata_i, 3)) else $error("duty readback");
  a_ind_ch3: assert property (sample_valid_i && sample_channel_i == 4'h3 ##[1:4] reg_rd_i && reg_addr_i == 8'h50
    |=> reg_rdata_o == 8'h10) else $error("channel 3 indication");
  // Main scenarios reached
  c_func_write: cover property (reg_wr_i && reg_addr_i == 8'h4f);
  c_mode_on: cover property ($rose(cal_rates_active_o));
  c_pwm_low: cover property ($rose(drive_output_port_oe_o[1]));
endmodule : tclr_regs_sva

// >>> verification/tclr_host.sv
// Host model: drives the register strobe port in place of the serial engine.
// Assumes one clock; requests launch 1 ns after a rising edge.
`timescale 1ns/10ps
module tclr_host (
  input wire logic core_clk_i,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i,
  output logic [7:0] reg_addr_o = 8'h00,
  output logic reg_wr_o = 1'b0,
  output logic [7:0] reg_wdata_o = 8'h00,
  output logic reg_rd_o = 1'b0
);
  // One write strobe; released lines show inverted values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i) #1;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(posedge core_clk_i) #1;
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask : wr
  // One read; data taken while the answer pulse stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i) #1;
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(posedge core_clk_i) #1;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 8'hxx;
  endtask : rd
endmodule : tclr_host

// >>> verification/tb.sv
// Testbench for the register group: host model, sample stimulus and checks.
// Assumes package and design are compiled first; the checker is bound below.
`timescale 1ns/10ps
module tb;
  import tclr_pkg::*;
  logic core_clk_i = 1'b0, sys_rst_i = 1'b1, mode = 1'b0, sv = 1'b0, wr, rd, rvalid, active;
  logic [7:0] addr, wdata, rdata, oe, port, d, hi, lo, touch = 8'h00;
  logic [3:0] sch = 4'h0;
  logic [25:0] slev = 26'h0;
  logic [1:0] sf, sr, nf, nr, k;
  logic [15:0] n0, n1, n2;
  int error_cnt = 0, checked = 0;
  always #4 core_clk_i = ~core_clk_i;
  tclr_host host (.core_clk_i(core_clk_i), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid), .reg_addr_o(addr),
    .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rd_o(rd));
  tclr_regs dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .secondary_calibration_mode_i(mode), .touch_result_i(touch), .sample_valid_i(sv), .sample_channel_i(sch),
    .sample_level_i(slev), .cal_rates_active_o(active), .sense_cal_rate_falling_o(sf),
    .sense_cal_rate_rising_o(sr), .noise_ref_cal_rate_falling_o(nf), .noise_ref_cal_rate_rising_o(nr),
    .drive_output_port_o(port), .drive_output_port_oe_o(oe));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  // Reset values; 47h-4Eh unmapped also read zero
  task automatic t_reset();
    host.rd(ADDR_BS_CAL_SPEED, d);
    chk(d, 8'h66, "speed reg");
    chk({sf, sr, nf, nr}, 8'h99, "rate outputs");
    chk(active, 1'b0, "mode idle after reset");
    for (int a = 8'h43; a <= 8'h4f; a++) begin
      host.rd(a[7:0], d);
      chk(d, 8'h00, "duty or function reset");
    end
  endtask : t_reset
  // Every rate code in every field, distinct per field
  task automatic t_cal();
    mode = 1'b1;
    for (int i = 0; i < 4; i++) begin
      k = i[1:0];
      host.wr(ADDR_BS_CAL_SPEED, {k + 2'h3, k + 2'h2, k + 2'h1, k});
      @(posedge core_clk_i) #1;
      chk({nr, nf, sr, sf}, {k + 2'h3, k + 2'h2, k + 2'h1, k}, "rates");
    end
    chk(active, 1'b1, "mode active");
    mode = 1'b0;
    @(posedge core_clk_i) #1;
    chk(active, 1'b0, "mode inactive");
  endtask : t_cal
  // Duty bytes, then PWM low time over one period
  task automatic t_duty();
    for (int p = 0; p < 4; p++) begin
      host.wr(ADDR_LED_DUTY_12 + p[7:0], 8'h10 + 8'h22 * p[7:0]);
      host.rd(ADDR_LED_DUTY_12 + p[7:0], d);
      chk(d, 8'h10 + 8'h22 * p[7:0], "duty byte");
    end
    host.wr(ADDR_LED_DUTY_12, 8'hf0);
    host.wr(ADDR_LED_DUTY_34, 8'h07);
    host.wr(ADDR_OUT_FUNC_SEL, 8'h07);
    n0 = 16'h0;
    n1 = 16'h0;
    n2 = 16'h0;
    repeat (int'(PWM_SLOT_CYCLES) * int'(PWM_SLOTS)) begin
      @(posedge core_clk_i) #1;
      n0 = n0 + oe[0];
      n1 = n1 + oe[1];
      n2 = n2 + oe[2];
    end
    chk(n0, 16'(PWM_SLOT_CYCLES), "low time duty 0");
    chk(n1, 16'(PWM_SLOT_CYCLES) * 16'd16, "low time duty f");
    chk(n2, 16'(PWM_SLOT_CYCLES) * 16'd8, "low time duty 7");
  endtask : t_duty
  // Parallel touch output on every port
  task automatic t_touch();
    host.wr(ADDR_OUT_FUNC_SEL, 8'h00);
    touch = 8'ha5;
    repeat (3) @(posedge core_clk_i);
    #1;
    chk(oe, 8'ha5, "touch outputs");
    chk(port, 8'h00, "pin value");
  endtask : t_touch
  // Channels 0..8 plus an ignored 9; readback writes ignored
  task automatic t_chan();
    logic [7:0] a [7] = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h56, 8'h57};
    logic [25:0] lev;
    logic [7:0] e;
    for (int c = 0; c <= 9; c++) begin
      @(posedge core_clk_i) #1;
      sv = 1'b1;
      sch = c[3:0];
      slev = 26'h2aaaaab ^ (26'h0123457 * c[25:0]);
      @(posedge core_clk_i) #1;
      sv = 1'b0;
      if (c <= 8) begin
        lev = slev;
        hi = (c == 0) ? 8'h02 : (c < 7) ? 8'h02 << c : 8'h00;
        lo = (c == 7) ? 8'h01 : (c == 8) ? 8'h02 : 8'h00;
      end
      for (int j = 0; j < 7; j++) begin
        host.rd(a[j], d);
        e = (j == 2) ? lev[25:18] : (j == 3) ? lev[17:10] : (j == 4) ? lev[9:2] : (j % 5 != 0) ? lo : hi;
        chk(d, e, "readback");
      end
      host.wr(a[c % 7], 8'hff);
    end
  endtask : t_chan
  // Reset in mid-run brings back the values after reset
  task automatic t_mid_reset();
    host.wr(ADDR_BS_CAL_SPEED, 8'h1b);
    @(posedge core_clk_i) #1;
    sys_rst_i = 1'b1;
    @(posedge core_clk_i) #1;
    sys_rst_i = 1'b0;
    host.rd(ADDR_BS_CAL_SPEED, d);
    chk(d, 8'h66, "speed after mid reset");
    host.rd(ADDR_LEVEL_UPPER, d);
    chk(d, 8'h00, "level after mid reset");
  endtask : t_mid_reset
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge core_clk_i);
    #1 sys_rst_i = 1'b0;
    t_reset();
    t_cal();
    t_duty();
    t_touch();
    t_chan();
    t_mid_reset();
    conclude();
  end
endmodule : tb
bind tclr_regs tclr_regs_sva sva (.*);
